// ===== hdl/dmc_regs.svh
// Register indices, reset values and codes of the DMA channel block.
// Included by every design file but the package; definitions only.
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// Register indices; byte address on APB is four times the index
`define DMC_CHAN0_CONTROL 12'hfb0
`define DMC_CHAN1_CONTROL 12'hfb8
`define DMC_OFS_CONTROL   12'h000
`define DMC_OFS_PERIPH    12'h001
`define DMC_OFS_HIGH      12'h002
`define DMC_OFS_START     12'h003
`define DMC_OFS_END       12'h004
`define DMC_CHAN_REGS     12'h005

// Reset values
`define DMC_CTL_RESET     8'h00
`define DMC_ADDR_RESET    8'h00

// Peripheral control register page
`define DMC_PERIPH_PAGE   4'hf

// Trigger select codes
`define DMC_TRIG_TIMER0   3'h0
`define DMC_TRIG_TIMER1   3'h1
`define DMC_TRIG_TIMER3   3'h2
`define DMC_TRIG_UART0    3'h4
`define DMC_TRIG_UART1    3'h5
`define DMC_TRIG_TWI      3'h6

// Address steps per transfer
`define DMC_STEP_BYTE     12'h001
`define DMC_STEP_WORD     12'h002

`endif

// ===== hdl/dmc_pkg.sv
// Types shared by the DMA channel block.
// Assumes nothing of its surroundings.
package dmc_pkg;

    typedef struct packed {
        logic       chan_enable;
        logic       loop_enable;
        logic       xfer_direction;
        logic       end_irq_enable;
        logic       word_select;
        logic [2:0] trigger_select;
    } dmc_ctl_t;

    typedef struct packed {
        logic [2:0] timer;
        logic [1:0] uart_rx_valid;
        logic [1:0] uart_tx_empty;
        logic       twi_rx;
        logic       twi_tx;
    } dmc_trig_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } dmc_mem_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ,
        ST_RD,
        ST_CAP,
        ST_WR
    } dmc_state_t;

endpackage

// ===== hdl/dmc_trig.sv
// Trigger source selection and pending request of one channel.
// Assumes trigger levels come from logic on the same clock.
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_trig #(
    parameter int CHAN = 0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Sources and selection
    input  wire dmc_pkg::dmc_trig_t trig,
    input  wire logic [2:0]        trigger_select,
    input  wire logic              chan_enable,
    // Engine side
    input  wire logic              take,
    output logic                   pending
);
    import dmc_pkg::*;

    logic src_prev;
    // Channel 0 watches receive side, channel 1 transmit side
    wire uart0 = (CHAN == 0) ? trig.uart_rx_valid[0]
                             : trig.uart_tx_empty[0];      // [RL10]
    wire uart1 = (CHAN == 0) ? trig.uart_rx_valid[1]
                             : trig.uart_tx_empty[1];      // [RL11]
    wire twi   = (CHAN == 0) ? trig.twi_rx : trig.twi_tx;  // [RL12]
    // Raw peripheral requests, no interrupt controller gating [RL13]
    wire src =
        (trigger_select == `DMC_TRIG_TIMER0) ? trig.timer[0] : // [RL9]
        (trigger_select == `DMC_TRIG_TIMER1) ? trig.timer[1] :
        (trigger_select == `DMC_TRIG_TIMER3) ? trig.timer[2] :
        (trigger_select == `DMC_TRIG_UART0)  ? uart0 :
        (trigger_select == `DMC_TRIG_UART1)  ? uart1 :
        (trigger_select == `DMC_TRIG_TWI)    ? twi : 1'b0; // [RL12]
    wire rise = src & ~src_prev;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_prev <= 1'b0;
            pending  <= 1'b0;
        end else begin
            src_prev <= src;
            if (!chan_enable) begin
                pending <= 1'b0;                    // [RL1]
            end else if (rise) begin
                pending <= 1'b1;                    // [RL1] [RL19]
            end else if (take) begin
                pending <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_disabled_quiet: assert property ( // [RL1]
        !chan_enable |=> !pending)
        else $error("pending set while channel disabled");
    a_pend_hold: assert property ( // [RL19]
        (chan_enable && rise) |=> pending)
        else $error("trigger lost");
endmodule

// ===== hdl/dmc_addr.sv
// Start and current address of one channel with end compare.
// Assumes load and step never occur in the same cycle's intent.
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_addr (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Software load
    input  wire logic        load,
    input  wire logic [11:0] load_val,
    // Transfer progress
    input  wire logic        step,
    input  wire logic        word_select,
    input  wire logic [11:0] end_addr,
    // State
    output logic      [11:0] start_addr,
    output logic      [11:0] cur_addr,
    output logic             at_end
);
    assign at_end = (cur_addr == end_addr);
    wire [11:0] incr = word_select ? `DMC_STEP_WORD : `DMC_STEP_BYTE;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_addr <= 12'h000;
            cur_addr   <= 12'h000;
        end else if (load) begin
            start_addr <= load_val;
            cur_addr   <= load_val;
        end else if (step) begin
            if (at_end) begin
                cur_addr <= start_addr;             // [RL2] [RL3]
            end else begin
                cur_addr <= cur_addr + incr;        // [RL16]
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_addr_step: assert property ( // [RL16]
        (step && !load && !at_end) |=>
            cur_addr == $past(cur_addr) +
                ($past(word_select) ? `DMC_STEP_WORD : `DMC_STEP_BYTE))
        else $error("current address step wrong");
    a_end_reload: assert property ( // [RL3]
        (step && !load && at_end) |=> cur_addr == $past(start_addr))
        else $error("start address not reloaded");
endmodule

// ===== hdl/dmc_top.sv
// Two general DMA channels with APB registers and a system bus master.
// Assumes bus_ack, triggers and memory on clk; memory read data valid
// two cycles after the cycle in which re is issued.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "dmc_regs.svh"
// Functional notes
// [RL1] Disabled channel ignores triggers; enabled starts transfers
// [RL2] Single pass: reload start, then disable
// [RL3] Loop mode: reload start, keep running
// [RL4] Direction bit chooses source and destination
// [RL5] Interrupt at end only when enabled
// [RL6] Byte mode moves one byte per trigger
// [RL7] Word mode moves two bytes per trigger
// [RL8] Software keeps peripheral address even in word mode
// [RL9] Codes 000, 001, 010 select timers 0, 1, 3
// [RL10] Code 100: first serial port rx/tx
// [RL11] Code 101: second serial port rx/tx
// [RL12] Code 110: two-wire rx/tx; 111 selects nothing
// [RL13] Triggers ignore interrupt controller enables
// [RL14] Peripheral must enable its own request gate
// [RL15] Request bus, await acknowledge, transfer, release
// [RL16] Advance address by 1 or 2
// [RL17] Peripheral address is page F plus low byte
// [RL18] Start and end addresses are 12 bits
// [RL19] Trigger during transfer is held, not lost
// [RL20] Self-disable shows enable cleared on read
module dmc_top (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // APB slave
    input  wire logic [15:0]        paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Trigger sources
    input  wire dmc_pkg::dmc_trig_t trig,
    // System bus
    output logic                    bus_req,
    input  wire logic               bus_ack,
    output dmc_pkg::dmc_mem_t       mem,
    input  wire logic [7:0]         mem_rdata,
    // Interrupt requests
    output logic      [1:0]         irq_req
);
    import dmc_pkg::*;

    localparam int NCH = 2;

    dmc_ctl_t    chan_control    [NCH];
    logic [7:0]  periph_addr_low [NCH];
    logic [3:0]  end_hi          [NCH];
    logic [7:0]  end_lo          [NCH];
    logic [11:0] start_addr      [NCH];
    logic [11:0] cur_addr        [NCH];
    logic [7:0]  rd_byte         [NCH];
    logic [NCH-1:0] hit;
    logic [NCH-1:0] at_end;
    logic [NCH-1:0] pending;
    logic [NCH-1:0] irq_en;
    logic [NCH-1:0] take;
    logic [NCH-1:0] step;
    dmc_state_t  state;
    logic        act;
    logic        second;

    // APB decode
    wire [11:0] idx     = paddr[13:2];
    wire        aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    wire        setup   = psel & ~penable;
    wire        wr_en   = psel & penable & pready & pwrite;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_chan
            wire [11:0] base = (c == 0) ? `DMC_CHAN0_CONTROL
                                        : `DMC_CHAN1_CONTROL;
            wire [11:0] rel  = idx - base;
            wire in_ch  = aligned && (idx >= base) &&
                          (rel < `DMC_CHAN_REGS);
            wire h_ctl  = in_ch && (rel == `DMC_OFS_CONTROL);
            wire h_io   = in_ch && (rel == `DMC_OFS_PERIPH);
            wire h_hi   = in_ch && (rel == `DMC_OFS_HIGH);
            wire h_st   = in_ch && (rel == `DMC_OFS_START);
            wire h_end  = in_ch && (rel == `DMC_OFS_END);
            wire ld     = wr_en && (h_hi || h_st);
            // 12-bit start built from high nibble and low byte [RL18]
            wire [11:0] ld_val = h_hi ? {pwdata[3:0], start_addr[c][7:0]}
                                      : {start_addr[c][11:8], pwdata[7:0]};
            wire self_off = step[c] && at_end[c] &&
                            !chan_control[c].loop_enable;
            assign hit[c]    = in_ch;
            assign irq_en[c] = chan_control[c].end_irq_enable;
            // Start register reads back the current address
            assign rd_byte[c] =
                h_ctl ? chan_control[c] :
                h_io  ? periph_addr_low[c] :
                h_hi  ? {end_hi[c], cur_addr[c][11:8]} :
                h_st  ? cur_addr[c][7:0] :
                h_end ? end_lo[c] : 8'h00;

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    chan_control[c] <= dmc_ctl_t'(`DMC_CTL_RESET);
                end else if (wr_en && h_ctl) begin
                    chan_control[c] <= dmc_ctl_t'(pwdata[7:0]);
                end else if (self_off) begin
                    chan_control[c].chan_enable <= 1'b0; // [RL2] [RL20]
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    periph_addr_low[c] <= `DMC_ADDR_RESET;
                    end_hi[c]          <= 4'h0;
                    end_lo[c]          <= `DMC_ADDR_RESET;
                end else if (wr_en) begin
                    if (h_io) begin
                        periph_addr_low[c] <= pwdata[7:0];
                    end
                    if (h_hi) begin
                        end_hi[c] <= pwdata[7:4];   // [RL18]
                    end
                    if (h_end) begin
                        end_lo[c] <= pwdata[7:0];
                    end
                end
            end

            dmc_trig #(
                .CHAN(c)
            ) u_trig (
                .clk           (clk),
                .rstn          (rstn),
                .trig          (trig),
                .trigger_select(chan_control[c].trigger_select),
                .chan_enable   (chan_control[c].chan_enable),
                .take          (take[c]),
                .pending       (pending[c])
            );

            dmc_addr u_addr (
                .clk        (clk),
                .rstn       (rstn),
                .load       (ld),
                .load_val   (ld_val),
                .step       (step[c]),
                .word_select(chan_control[c].word_select),
                .end_addr   ({end_hi[c], end_lo[c]}),
                .start_addr (start_addr[c]),
                .cur_addr   (cur_addr[c]),
                .at_end     (at_end[c])
            );
        end
    endgenerate

    wire [7:0] rd_mux = hit[0] ? rd_byte[0] : rd_byte[1];

    // Zero wait state: answer registered in the setup cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~|hit;
            if (setup) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Transfer engine; channel 0 wins when both are pending
    wire        is_idle = (state == ST_IDLE);
    wire        sel_ch  = ~pending[0];
    wire        dir     = chan_control[act].xfer_direction;
    wire        more    = chan_control[act].word_select & ~second;
    // Peripheral side on page F; word mode relies on even low byte [RL8]
    wire [11:0] per_a   = {`DMC_PERIPH_PAGE, periph_addr_low[act]} +
                          {11'h000, second};            // [RL17]
    wire [11:0] ram_a   = cur_addr[act] + {11'h000, second};
    wire [11:0] src_a   = dir ? per_a : ram_a;          // [RL4]
    wire [11:0] dst_a   = dir ? ram_a : per_a;          // [RL4]
    wire        last_wr = (state == ST_WR) && !more;

    assign take[0] = is_idle & pending[0];
    assign take[1] = is_idle & pending[1] & ~pending[0];
    assign step[0] = last_wr & ~act;
    assign step[1] = last_wr & act;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state   <= ST_IDLE;
            act     <= 1'b0;
            second  <= 1'b0;
            bus_req <= 1'b0;
            mem     <= '0;
        end else begin
            unique case (state)
                ST_IDLE: if (|pending) begin
                    act     <= sel_ch;
                    second  <= 1'b0;
                    bus_req <= 1'b1;                // [RL15]
                    state   <= ST_REQ;
                end
                ST_REQ: if (bus_ack) begin          // [RL15]
                    mem.addr <= src_a;
                    mem.re   <= 1'b1;
                    state    <= ST_RD;
                end
                ST_RD: begin
                    mem.re <= 1'b0;
                    state  <= ST_CAP;
                end
                ST_CAP: begin
                    mem.addr  <= dst_a;
                    mem.wdata <= mem_rdata;
                    mem.we    <= 1'b1;
                    state     <= ST_WR;
                end
                ST_WR: begin
                    mem.we <= 1'b0;
                    if (more) begin
                        second <= 1'b1;             // [RL7]
                        state  <= ST_REQ;
                    end else begin
                        bus_req <= 1'b0;            // [RL6] [RL15]
                        state   <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_req <= 2'b00;
        end else begin
            irq_req <= step & at_end & irq_en;      // [RL5]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_read_write;
        mem.re ##1 !mem.re ##1 mem.we;
    endsequence

    a_rd_then_wr: assert property ( // [RL15]
        mem.re |-> s_read_write)
        else $error("read not followed by write");
    a_ack_first: assert property ( // [RL15]
        $rose(mem.re) |-> $past(bus_ack) && bus_req)
        else $error("bus used without acknowledge");
    a_periph_src: assert property ( // [RL17]
        (mem.re && dir) |-> mem.addr[11:8] == `DMC_PERIPH_PAGE)
        else $error("peripheral source off page");
    a_periph_dst: assert property ( // [RL4]
        (mem.we && !dir) |-> mem.addr[11:8] == `DMC_PERIPH_PAGE)
        else $error("peripheral destination off page");
    a_byte_once: assert property ( // [RL6]
        (state == ST_REQ && bus_ack && !chan_control[act].word_select)
            |-> ##4 !bus_req)
        else $error("byte mode did not release bus");
    a_word_two: assert property ( // [RL7]
        (state == ST_REQ && bus_ack && more)
            |-> ##4 (state == ST_REQ && second))
        else $error("word mode missing second byte");
    a_single_off: assert property ( // [RL20]
        (step[0] && at_end[0] && !chan_control[0].loop_enable && !wr_en)
            |=> !chan_control[0].chan_enable)
        else $error("single pass did not disable");
    a_irq_gate: assert property ( // [RL5]
        irq_req[0] |-> $past(irq_en[0] && at_end[0] && step[0]))
        else $error("interrupt without enabled end");
    a_irq_fire: assert property ( // [RL5]
        (step[1] && at_end[1] && irq_en[1]) |=> irq_req[1])
        else $error("end interrupt missing");
endmodule

// ===== dv/dmc_cpu_model.sv
// Bus owner and register file on the far side of the DMA block.
// Assumes the block's memory handshake on clk; grant after ack_delay.
`timescale 1ns/1ps
module dmc_cpu_model (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Bus arbitration
    input  wire logic [3:0]        ack_delay,
    input  wire logic              bus_req,
    output logic                   bus_ack,
    // Register file port
    input  wire dmc_pkg::dmc_mem_t mem,
    output logic      [7:0]        mem_rdata
);
    import dmc_pkg::*;
    logic [7:0] ram [4096];
    logic [3:0] waited;
    logic       hold;
    // Grant after the wait, withdraw with the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_ack <= 1'b0;
            waited  <= 4'h0;
        end else if (!bus_req) begin
            bus_ack <= 1'b0;
            waited  <= 4'h0;
        end else if (waited >= ack_delay) begin
            bus_ack <= 1'b1;
        end else begin
            waited <= waited + 4'h1;
        end
    end
    // Read data stands two cycles, then the released lines toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_rdata <= 8'h00;
            hold      <= 1'b0;
        end else if (mem.re) begin
            mem_rdata <= ram[mem.addr];
            hold      <= 1'b1;
        end else if (hold) begin
            hold <= 1'b0;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    // Writes land only while the bus is granted
    always @(posedge clk) begin
        if (mem.we && bus_ack) begin
            ram[mem.addr] <= mem.wdata;
        end
    end
endmodule

// ===== dv/dma_channel_control_test.sv
// Self-checking bench for the two-channel DMA control block.
// Assumes the bus owner model beside it; APB driven at rising edges.
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dma_channel_control_test;
    import dmc_pkg::*;
    typedef struct packed {
        logic       ch;
        logic [7:0] ctl;
        logic [8:0] trg;
        logic       go;
    } dmc_row_t;
    logic        clk;
    logic        rstn;
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dmc_trig_t   trig;
    logic        bus_req;
    logic        bus_ack;
    dmc_mem_t    mem;
    logic [7:0]  mem_rdata;
    logic [1:0]  irq_req;
    logic [3:0]  ack_delay;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          checked = 0;
    int          irq_cnt [2] = '{0, 0};
    dmc_row_t    rows [13] = '{
        '{1'b0, 8'h80, 9'h040, 1'b1},
        '{1'b1, 8'ha9, 9'h080, 1'b1},
        '{1'b0, 8'h8a, 9'h100, 1'b1},
        '{1'b0, 8'ha4, 9'h010, 1'b1},
        '{1'b1, 8'h84, 9'h004, 1'b1},
        '{1'b0, 8'h8d, 9'h020, 1'b1},
        '{1'b1, 8'ha5, 9'h008, 1'b1},
        '{1'b0, 8'h86, 9'h002, 1'b1},
        '{1'b1, 8'hae, 9'h001, 1'b1},
        '{1'b0, 8'h87, 9'h1ff, 1'b0},
        '{1'b0, 8'h84, 9'h004, 1'b0},
        '{1'b0, 8'h00, 9'h040, 1'b0},
        '{1'b0, 8'h80, 9'h080, 1'b0}
    };

    dmc_top u_dut (
        .clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .trig, .bus_req, .bus_ack,
        .mem, .mem_rdata, .irq_req
    );
    dmc_cpu_model u_cpu (
        .clk, .rstn, .ack_delay, .bus_req, .bus_ack, .mem, .mem_rdata
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(negedge clk) begin
        if (irq_req[0] === 1'b1) irq_cnt[0]++;
        if (irq_req[1] === 1'b1) irq_cnt[1]++;
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function logic [11:0] base(input logic ch);
        return ch ? `DMC_CHAN1_CONTROL : `DMC_CHAN0_CONTROL;
    endfunction
    task apb(input logic w, input logic [11:0] idx, input logic [7:0] wd,
             output logic [31:0] d, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, idx, wd, d, e);
    endtask
    task rdc(input logic [11:0] idx, input logic [7:0] x);
        logic [31:0] d;
        logic        e;
        apb(1'b0, idx, 8'h00, d, e);
        chk($sformatf("reg %h", idx), d, {24'h0, x});
    endtask
    task cfg(input logic ch, input logic [7:0] io,
             input logic [11:0] s, e, input logic [7:0] c);
        wr(base(ch) + `DMC_OFS_PERIPH, io);
        wr(base(ch) + `DMC_OFS_HIGH, {e[11:8], s[11:8]});
        wr(base(ch) + `DMC_OFS_START, s[7:0]);
        wr(base(ch) + `DMC_OFS_END, e[7:0]);
        wr(base(ch), c);
    endtask
    task pulse(input logic [8:0] t);
        @(posedge clk);
        trig <= dmc_trig_t'(t);
        @(posedge clk);
        trig <= '0;
    endtask
    task wait_bus(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bus_req !== lvl && n < 80);
        chk("bus_req", bus_req, lvl);
    endtask
    task fire(input logic [8:0] t, input logic go);
        logic seen;
        seen = 1'b0;
        pulse(t);
        repeat (12) begin
            @(negedge clk);
            seen = seen | (bus_req === 1'b1);
        end
        chk("started", seen, go);
        wait_bus(1'b0);
    endtask
    task row(input dmc_row_t r, input int i);
        logic [11:0] s;
        logic [11:0] d;
        logic [7:0]  sv [2];
        logic [7:0]  dv [2];
        s = r.ctl[5] ? 12'hf40 : 12'h100;
        d = r.ctl[5] ? 12'h100 : 12'hf40;
        for (int k = 0; k < 2; k++) begin
            u_cpu.ram[12'h100 + k] = 8'(8'h10 + 2 * i + k);
            u_cpu.ram[12'hf40 + k] = 8'(8'he0 - 2 * i - k);
            sv[k] = u_cpu.ram[s + k];
            dv[k] = u_cpu.ram[d + k];
        end
        ack_delay <= 4'(i);
        cfg(r.ch, 8'h40, 12'h100, 12'h1f0, r.ctl);
        rdc(base(r.ch), r.ctl);
        fire(r.trg, r.go);
        chk("dst_lo", u_cpu.ram[d], r.go ? sv[0] : dv[0]);
        chk("dst_hi", u_cpu.ram[d + 12'h1],
            r.go && r.ctl[3] ? sv[1] : dv[1]);
        rdc(base(r.ch) + 12'h3,
            !r.go ? 8'h00 : r.ctl[3] ? 8'h02 : 8'h01);
        wr(base(r.ch), 8'h00);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        trig = '0;
        ack_delay = 4'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rdc(12'hfb0, 8'h00);
        rdc(12'hfb8, 8'h00);
        apb(1'b1, 12'h000, 8'hff, rd, er);
        chk("slverr", er, 1'b1);
        apb(1'b0, 12'hfb5, 8'h00, rd, er);
        chk("slverr", er, 1'b1);
        chk("unmapped", rd, 32'h0);
        for (int i = 0; i < 13; i++) row(rows[i], i);
        // Single pass with end interrupt
        ack_delay <= 4'h0;
        cfg(1'b0, 8'h40, 12'h200, 12'h201, 8'h90);
        fire(9'h040, 1'b1);
        rdc(12'hfb3, 8'h01);
        chk("irq0", irq_cnt[0], 0);
        fire(9'h040, 1'b1);
        repeat (2) @(negedge clk);
        chk("irq0", irq_cnt[0], 1);
        rdc(12'hfb3, 8'h00);
        rdc(12'hfb0, 8'h10);
        fire(9'h040, 1'b0);
        // Loop mode, word transfers, no interrupt
        cfg(1'b1, 8'h42, 12'h300, 12'h302, 8'hc9);
        repeat (2) fire(9'h080, 1'b1);
        rdc(12'hfbb, 8'h00);
        rdc(12'hfb8, 8'hc9);
        fire(9'h080, 1'b1);
        rdc(12'hfbb, 8'h02);
        chk("irq1", irq_cnt[1], 0);
        wr(12'hfb8, 8'h00);
        // Trigger arriving mid transfer under a slow grant
        ack_delay <= 4'h6;
        cfg(1'b0, 8'h40, 12'h400, 12'h4ff, 8'hc0);
        pulse(9'h040);
        wait_bus(1'b1);
        repeat (8) @(negedge clk);
        pulse(9'h040);
        wait_bus(1'b0);
        wait_bus(1'b1);
        wait_bus(1'b0);
        rdc(12'hfb3, 8'h02);
        // Reset in mid run
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rst_out", {pready, pslverr, bus_req, irq_req, mem}, 32'h0);
        rstn <= 1'b1;
        rdc(12'hfb0, 8'h00);
        rdc(12'hfb3, 8'h00);
        test_done;
    end
    // Limit well above the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done;
    end
endmodule
